// ==== module_register_window.sv ====
// Register window, port pins, output cells and memory selects.
`default_nettype none

// Contract
// - 256-byte window decoded from placed base
// - Pin-input registers return present pin levels
// - Ports A,B pins select I/O or address
// - Output latches drive pins set as outputs
// - Direction registers set pins input or output
// - Drive registers: open-drain or fast slew
// - Enable status reads actual driver enables
// - Output cells read back, written on load
// - Mask bits block writes to output cells
// - Main flash lock status read-only
// - Security and boot lock status read-only
// - Placement puts memories in program/data space; SRAM is always in data space
// - Two power registers and page register
// - Decode logic produces memory select signals
// - Test port programs all, no processor
// - Logic and configuration never processor-programmable
// - Processor bus: address, data, strobes
module module_register_window #(
	parameter logic [7:0] WINDOW_BASE = 8'hff
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       rd_strobe_b_i,
	input  wire logic       wr_strobe_b_i,
	input  wire logic       psen_b_i,
	input  wire logic       ale_i,
	input  wire logic       mcu_reset_b_i,
	output logic [7:0]      rdata_o,
	output logic            rdata_oe_o,
	input  wire logic [7:0] port_a_pin_i,
	input  wire logic [7:0] port_b_pin_i,
	input  wire logic [7:0] port_c_pin_i,
	input  wire logic [7:0] port_d_pin_i,
	output logic [7:0]      port_a_pin_o,
	output logic [7:0]      port_b_pin_o,
	output logic [7:0]      port_c_pin_o,
	output logic [7:0]      port_d_pin_o,
	output logic [7:0]      port_a_pin_oe_o,
	output logic [7:0]      port_b_pin_oe_o,
	output logic [7:0]      port_c_pin_oe_o,
	output logic [7:0]      port_d_pin_oe_o,
	output logic [7:0]      port_c_fast_slew_o,
	output logic [7:0]      port_d_fast_slew_o,
	output logic [7:0]      output_cells_one_o,
	output logic [7:0]      output_cells_two_o,
	input  wire logic [7:0] main_lock_status_i,
	input  wire logic [7:0] boot_lock_security_i,
	input  wire logic       test_port_active_i,
	output logic [7:0]      power_control_first_o,
	output logic [7:0]      power_control_second_o,
	output logic [7:0]      address_page_o,
	output logic [7:0]      memory_placement_o,
	output logic [7:0]      main_flash_select_o,
	output logic [3:0]      boot_flash_select_o,
	output logic            sram_select_o
);
	import psm_regwin_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Elaboration check

	// The window must not overlap the fixed memory regions
	if (WINDOW_BASE < LOWEST_FREE_HI) begin : g_bad_base
		$error("WINDOW_BASE overlaps a memory region");
	end

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// One 256-byte block whose upper byte is the base
	function automatic logic in_window(input logic [15:0] a);
		in_window = (a[15:8] == WINDOW_BASE);
	endfunction : in_window

	function automatic logic [7:0] window_offset(input logic [15:0] a);
		window_offset = a[7:0];
	endfunction : window_offset

	////////////////////////////////////////////////////////////////////////
	// Pin and test-port synchronisers

	logic [3:0][7:0] pin_meta_q;
	logic [3:0][7:0] pin_sync_q;
	logic            test_meta_q;
	logic            test_sync_q;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_meta_q  <= '0;
			pin_sync_q  <= '0;
			test_meta_q <= 1'b0;
			test_sync_q <= 1'b0;
		end else begin
			pin_meta_q  <= {port_d_pin_i, port_c_pin_i,
			                port_b_pin_i, port_a_pin_i};
			pin_sync_q  <= pin_meta_q;
			test_meta_q <= test_port_active_i;
			test_sync_q <= test_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus access

	logic       wr_prev_q;
	logic       wr_take;
	logic       rd_hit;
	logic [7:0] off;

	assign off = window_offset(addr_i);

	// One write per strobe: taken on its falling edge. The serial test
	// port owns the module while active, so processor writes are dropped.
	assign wr_take = wr_prev_q && !wr_strobe_b_i && in_window(addr_i)
	                 && !test_sync_q;
	assign rd_hit  = !rd_strobe_b_i && in_window(addr_i);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [3:0][7:0] latch_q;
	logic [3:0][7:0] latch_d;
	logic [3:0][7:0] dir_q;
	logic [3:0][7:0] dir_d;
	logic [3:0][7:0] drive_q;
	logic [3:0][7:0] drive_d;
	logic [1:0][7:0] func_q;
	logic [1:0][7:0] func_d;
	logic [1:0][7:0] cells_q;
	logic [1:0][7:0] cells_d;
	logic [1:0][7:0] mask_q;
	logic [1:0][7:0] mask_d;
	logic [7:0]      pwr_first_q;
	logic [7:0]      pwr_first_d;
	logic [7:0]      pwr_second_q;
	logic [7:0]      pwr_second_d;
	logic [7:0]      page_q;
	logic [7:0]      page_d;
	logic [7:0]      place_q;
	logic [7:0]      place_d;
	logic [15:0]     addr_lat_q;
	logic [15:0]     addr_lat_d;

	always_comb begin
		latch_d      = latch_q;
		dir_d        = dir_q;
		drive_d      = drive_q;
		func_d       = func_q;
		cells_d      = cells_q;
		mask_d       = mask_q;
		pwr_first_d  = pwr_first_q;
		pwr_second_d = pwr_second_q;
		page_d       = page_q;
		place_d      = place_q;
		// Address latch follows the bus while ALE is high
		addr_lat_d   = ale_i ? addr_i : addr_lat_q;
		if (wr_take) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (off == OFF_LATCH[p]) begin
					latch_d[p] = wdata_i;
				end
				if (off == OFF_DIR[p]) begin
					dir_d[p] = wdata_i;
				end
				if (off == OFF_DRIVE[p]) begin
					drive_d[p] = wdata_i;
				end
			end
			for (int g = 0; g < NUM_GROUPS; g++) begin
				if (off == OFF_FUNC[g]) begin
					func_d[g] = wdata_i;
				end
				// Masked bits keep their value on a load
				if (off == OFF_CELLS[g]) begin
					cells_d[g] = (cells_q[g] & mask_q[g])
					           | (wdata_i & ~mask_q[g]);
				end
				if (off == OFF_MASK[g]) begin
					mask_d[g] = wdata_i;
				end
			end
			// Lock and status offsets have no write path here; any other
			// offset simply matches nothing and changes nothing.
			case (off)
				OFF_PWR_FIRST: begin
					pwr_first_d = wdata_i;
				end
				OFF_PWR_SECOND: begin
					pwr_second_d = wdata_i;
				end
				OFF_PAGE: begin
					page_d = wdata_i;
				end
				OFF_PLACE: begin
					place_d = wdata_i;
				end
				default: begin
					place_d = place_d;
				end
			endcase
		end
		// Core reset strobe clears the control state like the pin reset
		if (!mcu_reset_b_i) begin
			latch_d      = '0;
			dir_d        = '0;
			drive_d      = '0;
			func_d       = '0;
			cells_d      = '0;
			mask_d       = '0;
			pwr_first_d  = RST_BYTE;
			pwr_second_d = RST_BYTE;
			page_d       = RST_BYTE;
			place_d      = RST_BYTE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			latch_q      <= '0;
			dir_q        <= '0;
			drive_q      <= '0;
			func_q       <= '0;
			cells_q      <= '0;
			mask_q       <= '0;
			pwr_first_q  <= RST_BYTE;
			pwr_second_q <= RST_BYTE;
			page_q       <= RST_BYTE;
			place_q      <= RST_BYTE;
			addr_lat_q   <= '0;
			wr_prev_q    <= 1'b1;
		end else begin
			latch_q      <= latch_d;
			dir_q        <= dir_d;
			drive_q      <= drive_d;
			func_q       <= func_d;
			cells_q      <= cells_d;
			mask_q       <= mask_d;
			pwr_first_q  <= pwr_first_d;
			pwr_second_q <= pwr_second_d;
			page_q       <= page_d;
			place_q      <= place_d;
			addr_lat_q   <= addr_lat_d;
			wr_prev_q    <= wr_strobe_b_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers

	logic [3:0][7:0] pin_d;
	logic [3:0][7:0] pin_q;
	logic [3:0][7:0] oe_d;
	logic [3:0][7:0] oe_q;

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic [7:0] val;
		if (p < NUM_GROUPS) begin : g_ab
			// A carries the low address byte, B the high byte
			assign val = (func_q[p] & addr_lat_q[p*8 +: 8])
			           | (~func_q[p] & latch_q[p]);
			// Open-drain pins only ever pull low
			assign pin_d[p] = val & ~drive_q[p];
			assign oe_d[p]  = (dir_q[p] | func_q[p])
			                & ~(drive_q[p] & val);
		end else begin : g_cd
			assign val      = latch_q[p];
			assign pin_d[p] = val;
			assign oe_d[p]  = dir_q[p];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_q <= '0;
			oe_q  <= '0;
		end else begin
			pin_q <= pin_d;
			oe_q  <= oe_d;
		end
	end

	assign port_a_pin_o       = pin_q[0];
	assign port_b_pin_o       = pin_q[1];
	assign port_c_pin_o       = pin_q[2];
	assign port_d_pin_o       = pin_q[3];
	assign port_a_pin_oe_o    = oe_q[0];
	assign port_b_pin_oe_o    = oe_q[1];
	assign port_c_pin_oe_o    = oe_q[2];
	assign port_d_pin_oe_o    = oe_q[3];
	assign port_c_fast_slew_o = drive_q[2];
	assign port_d_fast_slew_o = drive_q[3];

	assign output_cells_one_o     = cells_q[0];
	assign output_cells_two_o     = cells_q[1];
	assign power_control_first_o  = pwr_first_q;
	assign power_control_second_o = pwr_second_q;
	assign address_page_o         = page_q;
	assign memory_placement_o     = place_q;

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic [7:0] rd_val;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		rd_val = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (off == OFF_PIN_IN[p]) begin
				rd_val = pin_sync_q[p];
			end
			if (off == OFF_LATCH[p]) begin
				rd_val = latch_q[p];
			end
			if (off == OFF_DIR[p]) begin
				rd_val = dir_q[p];
			end
			if (off == OFF_DRIVE[p]) begin
				rd_val = drive_q[p];
			end
			if (off == OFF_OE_STAT[p]) begin
				rd_val = oe_q[p];
			end
		end
		// Input cells here capture the synchronised pins
		for (int p = 0; p < 3; p++) begin
			if (off == OFF_IN_CELLS[p]) begin
				rd_val = pin_sync_q[p];
			end
		end
		for (int g = 0; g < NUM_GROUPS; g++) begin
			if (off == OFF_FUNC[g]) begin
				rd_val = func_q[g];
			end
			if (off == OFF_CELLS[g]) begin
				rd_val = cells_q[g];
			end
			if (off == OFF_MASK[g]) begin
				rd_val = mask_q[g];
			end
		end
		case (off)
			OFF_PWR_FIRST: begin
				rd_val = pwr_first_q;
			end
			OFF_PWR_SECOND: begin
				rd_val = pwr_second_q;
			end
			OFF_MAIN_LOCK: begin
				rd_val = main_lock_status_i;
			end
			OFF_BOOT_LOCK: begin
				rd_val = boot_lock_security_i;
			end
			OFF_PAGE: begin
				rd_val = page_q;
			end
			OFF_PLACE: begin
				rd_val = place_q;
			end
			default: begin
				rd_val = rd_val;
			end
		endcase
		rdata_d = rd_hit ? rd_val : rdata_q;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Data lags the strobe by one edge; the core samples late in its cycle
	assign rdata_o    = rdata_q;
	assign rdata_oe_o = rd_hit;

	////////////////////////////////////////////////////////////////////////
	// Memory selects from the decode logic array

	logic prog_cyc;
	logic data_cyc;
	logic free_cyc;

	// Processor selects are held off while the test port programs, and
	// configuration has no processor path at all.
	assign prog_cyc = !psen_b_i && !test_sync_q;
	assign data_cyc = (!rd_strobe_b_i || !wr_strobe_b_i) && !test_sync_q;
	assign free_cyc = !in_window(addr_i);

	always_comb begin
		logic main_hit;
		logic boot_hit;
		logic sram_hit;
		main_hit = 1'b0;
		boot_hit = 1'b0;
		sram_hit = 1'b0;
		main_flash_select_o = '0;
		boot_flash_select_o = '0;
		if (free_cyc) begin
			main_hit = (addr_i[15] == REGION_MAIN_A15)
			         && ((prog_cyc && place_q[PL_MAIN_PROG])
			          || (data_cyc && place_q[PL_MAIN_DATA]));
			boot_hit = (addr_i[15:13] == REGION_BOOT_TOP)
			         && ((prog_cyc && place_q[PL_BOOT_PROG])
			          || (data_cyc && place_q[PL_BOOT_DATA]));
			sram_hit = (addr_i[15:13] == REGION_SRAM_TOP)
			         && ((prog_cyc && place_q[PL_SRAM_PROG])
			          || data_cyc);
		end
		// Page bit 0 extends the main flash to eight sectors
		if (main_hit) begin
			main_flash_select_o[{page_q[0], addr_i[14:13]}] = 1'b1;
		end
		if (boot_hit) begin
			boot_flash_select_o[addr_i[12:11]] = 1'b1;
		end
		sram_select_o = sram_hit;
	end

endmodule : module_register_window
`default_nettype wire

// ==== psm_regwin_pkg.sv ====
// Constants for the module register window: offsets, fields, resets.
`default_nettype none
package psm_regwin_pkg;

	localparam int unsigned WINDOW_BYTES = 256;
	localparam int unsigned NUM_PORTS    = 4;
	localparam int unsigned NUM_GROUPS   = 2;

	// Per port, index 0..3 is port A..D
	localparam logic [3:0][7:0] OFF_PIN_IN  = {8'h11, 8'h10, 8'h01, 8'h00};
	localparam logic [3:0][7:0] OFF_LATCH   = {8'h13, 8'h12, 8'h05, 8'h04};
	localparam logic [3:0][7:0] OFF_DIR     = {8'h15, 8'h14, 8'h07, 8'h06};
	localparam logic [3:0][7:0] OFF_DRIVE   = {8'h17, 8'h16, 8'h09, 8'h08};
	localparam logic [3:0][7:0] OFF_OE_STAT = {8'h1b, 8'h1a, 8'h0d, 8'h0c};
	// Ports A, B and C only
	localparam logic [2:0][7:0] OFF_IN_CELLS = {8'h18, 8'h0b, 8'h0a};
	// Ports A and B only
	localparam logic [1:0][7:0] OFF_FUNC    = {8'h03, 8'h02};
	// Output cell groups one and two
	localparam logic [1:0][7:0] OFF_CELLS   = {8'h21, 8'h20};
	localparam logic [1:0][7:0] OFF_MASK    = {8'h23, 8'h22};

	localparam logic [7:0] OFF_PWR_FIRST  = 8'hb0;
	localparam logic [7:0] OFF_PWR_SECOND = 8'hb4;
	localparam logic [7:0] OFF_MAIN_LOCK  = 8'hc0;
	localparam logic [7:0] OFF_BOOT_LOCK  = 8'hc2;
	localparam logic [7:0] OFF_PAGE       = 8'he0;
	localparam logic [7:0] OFF_PLACE      = 8'he2;

	localparam logic [7:0] RST_BYTE = 8'h00;

	// Placement register fields
	localparam int unsigned PL_MAIN_PROG = 0;
	localparam int unsigned PL_BOOT_PROG = 1;
	localparam int unsigned PL_SRAM_PROG = 2;
	localparam int unsigned PL_MAIN_DATA = 3;
	localparam int unsigned PL_BOOT_DATA = 4;

	// Fixed memory regions, by upper address bits
	localparam logic       REGION_MAIN_A15 = 1'b0;
	localparam logic [2:0] REGION_BOOT_TOP = 3'h4;
	localparam logic [2:0] REGION_SRAM_TOP = 3'h5;
	localparam logic [7:0] LOWEST_FREE_HI  = 8'hc0;

endpackage : psm_regwin_pkg
`default_nettype wire

// ==== regwin_chk.sv ====
// Port checker for the module register window.
`default_nettype none
module regwin_chk
	import psm_regwin_pkg::*;
#(
	parameter logic [7:0] WINDOW_BASE = 8'hff
) (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        rd_strobe_b_i,
	input wire logic        wr_strobe_b_i,
	input wire logic        mcu_reset_b_i,
	input wire logic        test_port_active_i,
	input wire logic [7:0]  main_lock_status_i,
	input wire logic [7:0]  boot_lock_security_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        rdata_oe_o,
	input wire logic [7:0]  port_c_pin_o,
	input wire logic [7:0]  port_c_fast_slew_o,
	input wire logic [7:0]  power_control_second_o,
	input wire logic [7:0]  address_page_o,
	input wire logic [7:0]  memory_placement_o,
	input wire logic [7:0]  main_flash_select_o,
	input wire logic [3:0]  boot_flash_select_o,
	input wire logic        sram_select_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////////
	// Write strobe edge the window takes, test port synced idle
	sequence take(logic [7:0] off);
		(!test_port_active_i)[*3] ##0 ($fell(wr_strobe_b_i)
			&& mcu_reset_b_i && addr_i == {WINDOW_BASE, off});
	endsequence
	sequence rd_at(logic [7:0] off);
		!rd_strobe_b_i && addr_i == {WINDOW_BASE, off};
	endsequence
	logic no_sel;
	assign no_sel = main_flash_select_o == 8'h00
		&& boot_flash_select_o == 4'h0 && !sram_select_o;
	////////////////////////////////////////////////////////////////////
	oe_window_a: assert property (rdata_oe_o ==
		(!rd_strobe_b_i && addr_i[15:8] == WINDOW_BASE))
		else $error("read enable disagrees with window decode");
	empty_zero_a: assert property (rd_at(8'h19) |=>
		rdata_o == 8'h00) else $error("empty offset read not zero");
	main_lock_a: assert property (rd_at(OFF_MAIN_LOCK) |=>
		rdata_o == $past(main_lock_status_i))
		else $error("main lock status read wrong");
	boot_lock_a: assert property (rd_at(OFF_BOOT_LOCK) |=>
		rdata_o == $past(boot_lock_security_i))
		else $error("boot lock status read wrong");
	page_load_a: assert property (take(OFF_PAGE) |=>
		address_page_o == $past(wdata_i)) else $error("page not loaded");
	power_load_a: assert property (take(OFF_PWR_SECOND) |=>
		power_control_second_o == $past(wdata_i))
		else $error("power register not loaded");
	slew_load_a: assert property (take(OFF_DRIVE[2]) |=>
		port_c_fast_slew_o == $past(wdata_i))
		else $error("port c drive type not loaded");
	latch_pin_a: assert property (take(OFF_LATCH[2]) |-> ##2
		port_c_pin_o == $past(wdata_i, 2))
		else $error("port c pins miss latch value");
	window_sel_a: assert property (addr_i[15:8] == WINDOW_BASE |->
		no_sel) else $error("memory select inside window");
	test_sel_a: assert property (test_port_active_i[*4] |->
		no_sel) else $error("memory select while test port active");
	test_wr_a: assert property (test_port_active_i[*3] ##0
		($fell(wr_strobe_b_i) && addr_i == {WINDOW_BASE, OFF_PAGE})
		|=> $stable(address_page_o)) else $error("write taken in test");
	mcu_clear_a: assert property (!mcu_reset_b_i |=>
		power_control_second_o == 8'h00 && address_page_o == 8'h00
		&& memory_placement_o == 8'h00) else $error("core reset missed");
endmodule : regwin_chk
`default_nettype wire

// ==== mcu_bus_model.sv ====
// Processor core model: byte reads and writes on the internal bus.
`default_nettype none
module mcu_bus_model (
	input  wire logic [0:0]  clk_sys_i,
	input  wire logic [7:0]  rdata_i,
	input  wire logic [12:0] sel_i,
	output var  logic [15:0] addr_o,
	output var  logic [7:0]  wdata_o,
	output var  logic        rd_b_o,
	output var  logic        wr_b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 16'h0000;
		wdata_o = 8'h00;
		rd_b_o = 1'b1;
		wr_b_o = 1'b1;
	end
	// Window writes, one write just above the window, and plain reads: never self-programs flash
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		wdata_o = d;
		wr_b_o = 1'b0;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		wr_b_o = 1'b1;
		// Released lines show garbage, not the last value
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d,
		output logic [12:0] s);
		@(negedge clk_sys_i);
		addr_o = a;
		rd_b_o = 1'b0;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		d = rdata_i;
		s = sel_i;
		rd_b_o = 1'b1;
		addr_o = ~a;
	endtask : rd
endmodule : mcu_bus_model
`default_nettype wire

// ==== module_register_window_tb_top.sv ====
// Self-checking bench for the module register window.
`default_nettype none
module module_register_window_tb_top;
	import psm_regwin_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] BASE = 8'hd0;
	localparam logic [21:0][7:0] RW = {8'he2, 8'he0, 8'hb4, 8'hb0,
		8'h23, 8'h22, 8'h21, 8'h20, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13,
		8'h12, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02};
	logic clk_sys_i, rst_b_i, mcu_reset_b_i, tp, rd_b, wr_b;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, c_o, c_oe, c_slew, cells, got, a_o;
	logic [3:0][7:0] pins;
	logic [12:0] sel, s;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	mcu_bus_model u_mcu (.clk_sys_i, .rdata_i(rdata), .sel_i(sel),
		.addr_o(addr), .wdata_o(wdata), .rd_b_o(rd_b), .wr_b_o(wr_b));
	module_register_window #(.WINDOW_BASE(BASE)) DUT (
		.clk_sys_i, .rst_b_i, .addr_i(addr), .wdata_i(wdata),
		.rd_strobe_b_i(rd_b), .wr_strobe_b_i(wr_b), .psen_b_i(1'b1),
		.ale_i(1'b0), .mcu_reset_b_i, .rdata_o(rdata), .rdata_oe_o(),
		.port_a_pin_i(pins[0]), .port_b_pin_i(pins[1]),
		.port_c_pin_i(pins[2]), .port_d_pin_i(pins[3]),
		.port_a_pin_o(a_o), .port_b_pin_o(), .port_c_pin_o(c_o),
		.port_d_pin_o(), .port_a_pin_oe_o(), .port_b_pin_oe_o(),
		.port_c_pin_oe_o(c_oe), .port_d_pin_oe_o(),
		.port_c_fast_slew_o(c_slew), .port_d_fast_slew_o(),
		.output_cells_one_o(cells), .output_cells_two_o(),
		.main_lock_status_i(8'ha5), .boot_lock_security_i(8'h1e),
		.test_port_active_i(tp), .power_control_first_o(),
		.power_control_second_o(), .address_page_o(),
		.memory_placement_o(), .main_flash_select_o(sel[7:0]),
		.boot_flash_select_o(sel[11:8]), .sram_select_o(sel[12]));
	////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			wrap_up();
		end
	end
	function automatic logic [7:0] pat(input logic [7:0] o);
		return o ^ 8'h5a;
	endfunction : pat
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check
	task automatic wx(input logic [7:0] o, input logic [7:0] d);
		u_mcu.wr({BASE, o}, d);
	endtask : wx
	task automatic rx(input logic [7:0] o, input logic [7:0] e);
		u_mcu.rd({BASE, o}, got, s);
		check(got, e);
	endtask : rx
	task automatic msel(input logic [15:0] a, input logic [12:0] e);
		u_mcu.rd(a, got, s);
		check(s[7:0], e[7:0]);
		check({3'h0, s[12:8]}, {3'h0, e[12:8]});
	endtask : msel
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////
	initial begin
		rst_b_i = 1'b0;
		mcu_reset_b_i = 1'b1;
		tp = 1'b0;
		pins = {8'h69, 8'h96, 8'hc3, 8'h3c};
		repeat (5) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		for (int i = 0; i < 22; i++) rx(RW[i], 8'h00);
		for (int i = 0; i < 22; i++) wx(RW[i], pat(RW[i]));
		for (int i = 0; i < 22; i++) rx(RW[i], pat(RW[i]));
		check(c_o, pat(8'h12));
		check(c_oe, pat(8'h14));
		check(c_slew, pat(8'h16));
		// Port A: function 58, latch 5e, drive 52, direction 5c, address 0
		check(a_o, 8'h04);
		rx(8'h0c, 8'h5c);
		rx(8'h1a, pat(8'h14));
		rx(8'h1b, pat(8'h15));
		$display("test registers done");
		// Mask 78 keeps bits 6..3, so both write values land only on bits 7 and 2..0
		wx(8'h20, 8'h00);
		rx(8'h20, 8'h78);
		wx(8'h20, 8'hff);
		rx(8'h20, 8'hff);
		check(cells, 8'hff);
		$display("test output cells done");
		wx(OFF_MAIN_LOCK, 8'h00);
		wx(OFF_BOOT_LOCK, 8'h00);
		rx(OFF_MAIN_LOCK, 8'ha5);
		rx(OFF_BOOT_LOCK, 8'h1e);
		for (int i = 0; i < 3; i++) wx(8'h19 + 8'(i * 115), 8'hff);
		for (int i = 0; i < 3; i++) rx(8'h19 + 8'(i * 115), 8'h00);
		$display("test read-only and empty done");
		repeat (2) begin
			for (int i = 0; i < 4; i++) rx(OFF_PIN_IN[i], pins[i]);
			rx(8'h0a, pins[0]);
			pins = ~pins;
			repeat (3) @(negedge clk_sys_i);
		end
		u_mcu.wr({8'hd1, 8'h12}, 8'h00);
		rx(8'h12, pat(8'h12));
		$display("test pins and window done");
		msel(16'h6000, 13'h0008);
		msel(16'h8800, 13'h0200);
		msel(16'ha000, 13'h1000);
		tp = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		msel(16'h6000, 13'h0000);
		wx(OFF_PAGE, 8'h00);
		rx(OFF_PAGE, pat(8'he0));
		tp = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		$display("test selects and test port done");
		mcu_reset_b_i = 1'b0;
		@(negedge clk_sys_i);
		mcu_reset_b_i = 1'b1;
		rx(OFF_PAGE, 8'h00);
		rx(OFF_LATCH[2], 8'h00);
		check(c_oe, 8'h00);
		$display("test core reset done");
		wrap_up();
	end
endmodule : module_register_window_tb_top
bind module_register_window regwin_chk #(.WINDOW_BASE(WINDOW_BASE)) u_chk (
	.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .rd_strobe_b_i,
	.wr_strobe_b_i, .mcu_reset_b_i, .test_port_active_i,
	.main_lock_status_i, .boot_lock_security_i, .rdata_o, .rdata_oe_o,
	.port_c_pin_o, .port_c_fast_slew_o, .power_control_second_o,
	.address_page_o, .memory_placement_o, .main_flash_select_o,
	.boot_flash_select_o, .sram_select_o);
`default_nettype wire
